// *** common/adc_acq_map.svh ***
// offsets, field positions, reset values and timing counts of the acquisition control
// assumes a 32-bit classic Wishbone slave with one register per aligned word
// Behaviour
// - result is 16 bits over low and high bytes, left-justified, unused lows zero
// - busy reads one while converting, zero once result available; resets zero
// - run-mode bit one means continuous, zero single-shot; single-shot after reset
// - start bit written one restarts converter only, reads back zero
// - power field bits stage3,stage2,stage1,converter; zero powers off and resets
// - a powered-off gain stage is bypassed, input wired to output
// - prescaler codes 00..11 divide oscillator by 1, 2, 8, 32; reset 00
// - both bias fields give 0.25, 0.5, 0.75, full current; reset 11
// - elementary count codes give 1, 2, 4, 8 conversions; reset 01
// - oversampling is eight times two to the field; reset 010
// - first stage gain bit gives gain 10 when one, 1 when zero; reset zero
// - second stage gain codes give 1, 2, 5, 10; reset 00
// - second stage offset bit3 sign, bits 2..0 magnitude in 0.2 steps; reset 0000
// - third stage gain is 0.08 times field; reset 000 1100
// - third stage offset bit6 sign, bits 5..0 magnitude in 0.08 steps; reset zero
// - reference select zero first, one second; cleared only by system reset
// - five-bit input select cleared to 00000 only by system reset
// - defaults bit one restores all fields but input and reference select, power to 0001 not 0000; reads zero
// - writing one to start or defaults bit begins a conversion; start is ignored while the converter is powered off
// - continuous mode requests a fresh conversion at each completion
// - writes to configuration registers one to five reset the gain stages
`ifndef ADC_ACQ_MAP_SVH
`define ADC_ACQ_MAP_SVH

`define IDX_RES_LO      3'h0
`define IDX_RES_HI      3'h1
`define IDX_CONV_CFG    3'h2
`define IDX_PWR_BIAS    3'h3
`define IDX_CLK_STAGE2  3'h4
`define IDX_GAIN13      3'h5
`define IDX_STAGE3_OFF  3'h6
`define IDX_INSEL_STAT  3'h7

`define BIT_START       7
`define BIT_RUN_MODE    1
`define BIT_BUSY        7
`define BIT_DEFAULTS    6

`define RST_ELEM_COUNT  2'h1
`define RST_OVERSAMPLE  3'h2
`define RST_BIAS        2'h3
`define RST_POWER       4'h0
`define DEF_POWER       4'h1
`define RST_PRESCALE    2'h0
`define RST_S2_GAIN     2'h0
`define RST_S2_OFF      4'h0
`define RST_S1_GAIN     1'h0
`define RST_S3_GAIN     7'h0C
`define RST_S3_OFF      7'h00
`define RST_INSEL       5'h00

`define RES_BASE_BITS   5'h06
`define SAMPLE_DIV_LAST 2'h3

`endif

// *** common/adc_acq_pkg.sv ***
// types shared by the acquisition control
// assumes the constants of adc_acq_map.svh alongside
package adc_acq_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] reg_index_t;
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_t;
endpackage : adc_acq_pkg

// *** design/adc_acquisition_control.sv ***
// register file, conversion sequencing and clock prescaling of the acquisition chain
// assumes a classic Wishbone master and a converter core that pulses DONE with a result
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "adc_acq_map.svh"

module adc_acquisition_control #(
  parameter int ADR_W = 8
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [ADR_W-1:0] WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic        CONV_DONE_IN,
  input  wire logic [15:0] CONV_RESULT_IN,
  output logic             CONV_REQ_OUT,
  output logic             BUSY_OUT,
  output logic             GAIN_RESET_OUT,
  output logic [3:0]       POWER_OUT,
  output logic [2:0]       BYPASS_OUT,
  output logic [1:0]       GAIN_BIAS_OUT,
  output logic [1:0]       CONV_BIAS_OUT,
  output logic [1:0]       ELEM_COUNT_OUT,
  output logic [2:0]       OVERSAMPLE_OUT,
  output logic             RUN_MODE_OUT,
  output logic [1:0]       PRESCALE_OUT,
  output logic             FIRST_GAIN_OUT,
  output logic [1:0]       SECOND_GAIN_OUT,
  output logic [3:0]       SECOND_OFFSET_OUT,
  output logic [6:0]       THIRD_GAIN_OUT,
  output logic [6:0]       THIRD_OFFSET_OUT,
  output logic [4:0]       INPUT_SELECT_OUT,
  output logic             REF_SELECT_OUT,
  output logic             PSCK_TICK_OUT,
  output logic             SAMPLE_TICK_OUT
);

  // divide limit per prescaler code
  function automatic logic [4:0] prescale_last(input logic [1:0] code);
    unique case (code)
      2'h0: prescale_last = 5'h00;
      2'h1: prescale_last = 5'h01;
      2'h2: prescale_last = 5'h07;
      2'h3: prescale_last = 5'h1F;
    endcase
  endfunction : prescale_last

  // keeps only the bits the digital filter really resolves
  function automatic logic [15:0] result_mask(input logic [2:0] oversampling_field, input logic [1:0] nel);
    logic [4:0] res;
    res = `RES_BASE_BITS + {1'b0, oversampling_field, 1'b0} + {3'h0, nel};
    if (res >= 5'h10) begin
      result_mask = 16'hFFFF;
    end else begin
      result_mask = 16'hFFFF << (5'h10 - res);
    end
  endfunction : result_mask

  // bus slave
  adc_acq_pkg::reg_index_t idx;
  logic                    req_new;
  logic                    mapped;
  logic                    wr_hit;
  logic                    next_ack;
  logic [31:0]             next_dat;

  assign idx     = WB_ADR_IN[4:2];
  assign req_new = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign mapped  = (WB_ADR_IN[ADR_W-1:5] == '0) && (WB_ADR_IN[1:0] == 2'h0);
  assign wr_hit  = req_new && WB_WE_IN && mapped && WB_SEL_IN[0];

  // configuration state
  adc_acq_pkg::reg_byte_t wbyte;
  logic       start_wr;
  logic       def_wr;
  logic [1:0] elem_count, next_elem_count;
  logic [2:0] oversample, next_oversample;
  logic       run_mode, next_run_mode;
  logic [1:0] conv_bias, next_conv_bias;
  logic [1:0] gain_bias, next_gain_bias;
  logic [3:0] power, next_power;
  logic [1:0] prescale, next_prescale;
  logic [1:0] s2_gain, next_s2_gain;
  logic [3:0] s2_off, next_s2_off;
  logic       s1_gain, next_s1_gain;
  logic [6:0] s3_gain, next_s3_gain;
  logic [6:0] s3_off, next_s3_off;
  logic [4:0] insel, next_insel;
  logic       refsel, next_refsel;
  logic [2:0] next_bypass;
  logic       next_gain_reset;

  assign wbyte    = WB_DAT_IN[7:0];
  assign start_wr = wr_hit && (idx == `IDX_CONV_CFG) && wbyte[`BIT_START];
  assign def_wr   = wr_hit && (idx == `IDX_INSEL_STAT) && wbyte[`BIT_DEFAULTS];

  // conversion state
  adc_acq_pkg::conv_state_t state, next_state;
  adc_acq_pkg::reg_byte_t   res_lo, next_res_lo;
  adc_acq_pkg::reg_byte_t   res_hi, next_res_hi;
  logic                     next_req;
  logic [15:0]              masked;

  assign masked = CONV_RESULT_IN & result_mask(oversample, elem_count);

  always_comb begin
    next_ack = req_new;
    next_dat = 32'h0000_0000;
    if (req_new && !WB_WE_IN && mapped) begin
      unique case (idx)
        `IDX_RES_LO:     next_dat[7:0] = res_lo;
        `IDX_RES_HI:     next_dat[7:0] = res_hi;
        // start bit always reads zero
        `IDX_CONV_CFG:   next_dat[7:0] = {1'b0, elem_count, oversample, run_mode, 1'b0};
        `IDX_PWR_BIAS:   next_dat[7:0] = {conv_bias, gain_bias, power};
        `IDX_CLK_STAGE2: next_dat[7:0] = {prescale, s2_gain, s2_off};
        `IDX_GAIN13:     next_dat[7:0] = {s1_gain, s3_gain};
        `IDX_STAGE3_OFF: next_dat[7:0] = {1'b0, s3_off};
        // defaults bit reads zero busy shows progress
        `IDX_INSEL_STAT: next_dat[7:0] = {state == adc_acq_pkg::CONV_RUN, 1'b0, insel, refsel};
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      WB_ACK_OUT <= next_ack;
      WB_DAT_OUT <= next_dat;
    end
  end

  always_comb begin
    next_elem_count = elem_count;
    next_oversample = oversample;
    next_run_mode   = run_mode;
    next_conv_bias  = conv_bias;
    next_gain_bias  = gain_bias;
    next_power      = power;
    next_prescale   = prescale;
    next_s2_gain    = s2_gain;
    next_s2_off     = s2_off;
    next_s1_gain    = s1_gain;
    next_s3_gain    = s3_gain;
    next_s3_off     = s3_off;
    next_insel      = insel;
    next_refsel     = refsel;
    next_gain_reset = 1'b0;
    if (wr_hit) begin
      unique case (idx)
        `IDX_CONV_CFG: begin
          next_elem_count = wbyte[6:5];
          next_oversample = wbyte[4:2];
          next_run_mode   = wbyte[`BIT_RUN_MODE];
        end
        `IDX_PWR_BIAS: begin
          next_conv_bias = wbyte[7:6];
          next_gain_bias = wbyte[5:4];
          next_power     = wbyte[3:0];
        end
        `IDX_CLK_STAGE2: begin
          next_prescale = wbyte[7:6];
          next_s2_gain  = wbyte[5:4];
          next_s2_off   = wbyte[3:0];
        end
        `IDX_GAIN13: begin
          next_s1_gain = wbyte[7];
          next_s3_gain = wbyte[6:0];
        end
        `IDX_STAGE3_OFF: next_s3_off = wbyte[6:0];
        `IDX_INSEL_STAT: begin
          next_insel  = wbyte[5:1];
          next_refsel = wbyte[0];
        end
        default: ;
      endcase
      // any write to registers one to five restarts the gain stages
      next_gain_reset = (idx >= `IDX_PWR_BIAS);
    end
    // defaults leave input and reference selection alone
    if (def_wr) begin
      next_elem_count = `RST_ELEM_COUNT;
      next_oversample = `RST_OVERSAMPLE;
      next_run_mode   = 1'b0;
      next_conv_bias  = `RST_BIAS;
      next_gain_bias  = `RST_BIAS;
      next_power      = `DEF_POWER;
      next_prescale   = `RST_PRESCALE;
      next_s2_gain    = `RST_S2_GAIN;
      next_s2_off     = `RST_S2_OFF;
      next_s1_gain    = `RST_S1_GAIN;
      next_s3_gain    = `RST_S3_GAIN;
      next_s3_off     = `RST_S3_OFF;
    end
    next_bypass = ~next_power[3:1];
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      elem_count     <= `RST_ELEM_COUNT;
      oversample     <= `RST_OVERSAMPLE;
      run_mode       <= 1'b0;
      conv_bias      <= `RST_BIAS;
      gain_bias      <= `RST_BIAS;
      power          <= `RST_POWER;
      prescale       <= `RST_PRESCALE;
      s2_gain        <= `RST_S2_GAIN;
      s2_off         <= `RST_S2_OFF;
      s1_gain        <= `RST_S1_GAIN;
      s3_gain        <= `RST_S3_GAIN;
      s3_off         <= `RST_S3_OFF;
      insel          <= `RST_INSEL;
      refsel         <= 1'b0;
      BYPASS_OUT     <= 3'h7;
      GAIN_RESET_OUT <= 1'b0;
    end else begin
      elem_count     <= next_elem_count;
      oversample     <= next_oversample;
      run_mode       <= next_run_mode;
      conv_bias      <= next_conv_bias;
      gain_bias      <= next_gain_bias;
      power          <= next_power;
      prescale       <= next_prescale;
      s2_gain        <= next_s2_gain;
      s2_off         <= next_s2_off;
      s1_gain        <= next_s1_gain;
      s3_gain        <= next_s3_gain;
      s3_off         <= next_s3_off;
      insel          <= next_insel;
      refsel         <= next_refsel;
      BYPASS_OUT     <= next_bypass;
      GAIN_RESET_OUT <= next_gain_reset;
    end
  end

  assign ELEM_COUNT_OUT    = elem_count;
  assign OVERSAMPLE_OUT    = oversample;
  assign RUN_MODE_OUT      = run_mode;
  assign CONV_BIAS_OUT     = conv_bias;
  assign GAIN_BIAS_OUT     = gain_bias;
  assign POWER_OUT         = power;
  assign PRESCALE_OUT      = prescale;
  assign SECOND_GAIN_OUT   = s2_gain;
  assign SECOND_OFFSET_OUT = s2_off;
  assign FIRST_GAIN_OUT    = s1_gain;
  assign THIRD_GAIN_OUT    = s3_gain;
  assign THIRD_OFFSET_OUT  = s3_off;
  assign INPUT_SELECT_OUT  = insel;
  assign REF_SELECT_OUT    = refsel;

  // sequencing; a powered-down converter drops everything in flight
  always_comb begin
    next_state  = state;
    next_res_lo = res_lo;
    next_res_hi = res_hi;
    next_req    = 1'b0;
    if (!power[0]) begin
      next_state = adc_acq_pkg::CONV_IDLE;
    end else begin
      if (state == adc_acq_pkg::CONV_RUN && CONV_DONE_IN) begin
        next_res_lo = masked[7:0];
        next_res_hi = masked[15:8];
        next_state  = adc_acq_pkg::CONV_IDLE;
        next_req    = run_mode;
      end
      // a request in the completion cycle wins, busy stays set
      if (start_wr || def_wr) begin
        next_req = 1'b1;
      end
      if (next_req) begin
        next_state = adc_acq_pkg::CONV_RUN;
      end
    end
    // defaults mode powers the converter itself, so its request stands even from off
    if (def_wr) begin
      next_req   = 1'b1;
      next_state = adc_acq_pkg::CONV_RUN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state        <= adc_acq_pkg::CONV_IDLE;
      res_lo       <= 8'h00;
      res_hi       <= 8'h00;
      CONV_REQ_OUT <= 1'b0;
      BUSY_OUT     <= 1'b0;
    end else begin
      state        <= next_state;
      res_lo       <= next_res_lo;
      res_hi       <= next_res_hi;
      CONV_REQ_OUT <= next_req;
      BUSY_OUT     <= (next_state == adc_acq_pkg::CONV_RUN);
    end
  end

  // prescaler; sample tick is psck divided by four
  logic [4:0] psck_cnt, next_psck_cnt;
  logic [1:0] fs_cnt, next_fs_cnt;
  logic       next_psck_tick;
  logic       next_sample_tick;

  always_comb begin
    next_psck_cnt    = psck_cnt + 5'h01;
    next_fs_cnt      = fs_cnt;
    next_psck_tick   = 1'b0;
    next_sample_tick = 1'b0;
    // >= so a shorter code taken mid-count never runs past its limit
    if (psck_cnt >= prescale_last(prescale)) begin
      next_psck_cnt    = 5'h00;
      next_psck_tick   = 1'b1;
      next_fs_cnt      = fs_cnt + 2'h1;
      next_sample_tick = (fs_cnt == `SAMPLE_DIV_LAST);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      psck_cnt        <= 5'h00;
      fs_cnt          <= 2'h0;
      PSCK_TICK_OUT   <= 1'b0;
      SAMPLE_TICK_OUT <= 1'b0;
    end else begin
      psck_cnt        <= next_psck_cnt;
      fs_cnt          <= next_fs_cnt;
      PSCK_TICK_OUT   <= next_psck_tick;
      SAMPLE_TICK_OUT <= next_sample_tick;
    end
  end

  ack_single_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");

  start_zero_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (req_new && !WB_WE_IN && mapped && idx == `IDX_CONV_CFG) |=> !WB_DAT_OUT[`BIT_START])
    else $error("start bit read back as one");

  start_req_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (start_wr && power[0]) |=> (CONV_REQ_OUT && BUSY_OUT))
    else $error("start write did not request a conversion");

  def_req_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    def_wr |=> (CONV_REQ_OUT && BUSY_OUT))
    else $error("defaults write did not request a conversion");

  busy_clear_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (BUSY_OUT && CONV_DONE_IN && power[0] && !run_mode && !start_wr && !def_wr)
    |=> (!BUSY_OUT && {res_hi, res_lo} == $past(masked)))
    else $error("completion did not load result and clear busy");

  run_mode_bit_rereq_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (BUSY_OUT && CONV_DONE_IN && power[0] && run_mode) |=> (CONV_REQ_OUT && BUSY_OUT))
    else $error("continuous mode did not request again");

  gain_reset_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_hit && idx >= `IDX_PWR_BIAS) |=> GAIN_RESET_OUT ##1 !GAIN_RESET_OUT)
    else $error("gain stages not reset by configuration write");

  defaults_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    def_wr |=> (power == `DEF_POWER && oversample == `RST_OVERSAMPLE
                && insel == $past(wbyte[5:1]) && BYPASS_OUT == 3'h7))
    else $error("defaults mode did not restore fields");

  bypass_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    BYPASS_OUT == ~power[3:1])
    else $error("bypass disagrees with stage power");

  off_idle_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (!power[0] && !def_wr) |=> !BUSY_OUT)
    else $error("powered-down converter still busy");

  sample_tick_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (SAMPLE_TICK_OUT && prescale == 2'h0) ##1 (prescale == 2'h0) [*3] |=> SAMPLE_TICK_OUT)
    else $error("undivided sample tick not every fourth cycle");

  // reset in the antecedent so the release edge starts no attempt
  psck_tick_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (RST_N_IN && prescale == 2'h0) |=> PSCK_TICK_OUT)
    else $error("undivided prescaler missed a tick");

endmodule : adc_acquisition_control

// *** testbench/conv_core_model.sv ***
// behavioural converter core answering each request after a set latency
// assumes one-cycle request pulses on the control block's clock
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        req_in,
  input  wire logic        enable_in,
  input  wire logic [7:0]  latency_in,
  input  wire logic [15:0] value_in,
  output logic             done_out,
  output logic [15:0]      result_out
);
  logic [7:0] count;
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    // result lines toggle outside the done cycle so a stale value never matches
    result_out <= ~result_out;
    if (!rst_n_in || !enable_in) begin
      count      <= 8'h00;
      result_out <= 16'h5A5A;
    end else if (req_in) begin
      count <= latency_in;
    end else if (count == 8'h01) begin
      count      <= 8'h00;
      done_out   <= 1'b1;
      result_out <= value_in;
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
    end
  end
endmodule : conv_core_model

// *** testbench/testbench.sv ***
// self-checking bench for the acquisition control block
// assumes the converter core model beside it and a 40 MHz clock
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_n, cyc, stb, we, ack, done, req, busy, grst, run, ptick, stick;
  logic        seen_req, seen_busy, seen_grst;
  logic [7:0]  adr, lat, v, pw, d;
  logic [3:0]  wsel, power;
  logic [2:0]  bypass;
  wire  [4:0]  cfg_pins;
  wire  [3:0]  bias_pins;
  wire  [7:0]  clk_pins, g13_pins;
  wire  [6:0]  off_pins;
  wire  [5:0]  sel_pins;
  logic [15:0] res, val;
  logic [31:0] wdat, rdat, g;
  logic [7:0]  q[$];
  int          fail_count, tests_run, nr, lowseen;
  logic [7:0]  rst_tab[8] = '{8'h00, 8'h00, 8'h28, 8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00};
  logic [7:0]  cfg_tab[2] = '{8'hFC, 8'h80};
  logic [15:0] msk_tab[2] = '{16'hFFFF, 16'hFC00};
  logic [31:0] div_tab[4] = '{32'h1, 32'h2, 32'h8, 32'h20};

  adc_acquisition_control dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(wsel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .CONV_DONE_IN(done), .CONV_RESULT_IN(res),
    .CONV_REQ_OUT(req), .BUSY_OUT(busy), .GAIN_RESET_OUT(grst), .POWER_OUT(power),
    .BYPASS_OUT(bypass), .GAIN_BIAS_OUT(bias_pins[1:0]), .CONV_BIAS_OUT(bias_pins[3:2]),
    .ELEM_COUNT_OUT(cfg_pins[4:3]), .OVERSAMPLE_OUT(cfg_pins[2:0]), .RUN_MODE_OUT(run),
    .PRESCALE_OUT(clk_pins[7:6]), .FIRST_GAIN_OUT(g13_pins[7]),
    .SECOND_GAIN_OUT(clk_pins[5:4]), .SECOND_OFFSET_OUT(clk_pins[3:0]),
    .THIRD_GAIN_OUT(g13_pins[6:0]), .THIRD_OFFSET_OUT(off_pins),
    .INPUT_SELECT_OUT(sel_pins[5:1]), .REF_SELECT_OUT(sel_pins[0]),
    .PSCK_TICK_OUT(ptick), .SAMPLE_TICK_OUT(stick));

  conv_core_model core (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .enable_in(power[0]),
    .latency_in(lat), .value_in(val), .done_out(done), .result_out(res));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // configuration pins in register layout, to compare with the bytes written
  function automatic logic [31:0] pin_word(input int i);
    case (i)
      2: pin_word = {25'h0, cfg_pins, run, 1'b0};
      3: pin_word = {24'h0, bias_pins, power};
      4: pin_word = {24'h0, clk_pins};
      5: pin_word = {24'h0, g13_pins};
      6: pin_word = {25'h0, off_pins};
      default: pin_word = {26'h0, sel_pins};
    endcase
  endfunction : pin_word

  // entered just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dt,
                     input logic [3:0] s);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wsel <= s;
    wdat <= {24'h000000, dt};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk({31'h0, n < 50}, 32'h1);
    seen_req  = req;
    seen_busy = busy;
    seen_grst = grst;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    bus(1'b1, a, dt, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rd

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
  endtask : wait_idle

  task automatic gap(input logic s, output logic [31:0] gp);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((s ? stick : ptick) !== 1'b1 && n < 300);
    gp = 0;
    do begin
      @(posedge clk);
      gp++;
    end while ((s ? stick : ptick) !== 1'b1 && gp < 300);
  endtask : gap

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // read data is judged against the oldest note of the reader
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (q.size() == 0) begin
        chk(rdat, 32'hFFFFFFFF);
      end else begin
        chk(rdat, {24'h000000, q.pop_front()});
      end
    end
  end

  initial begin
    #(25 * 30000);
    fail_count++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wsel = 4'h0;
    wdat = 32'h0;
    lat = 8'h04;
    val = 16'h0000;
    void'($urandom(32'h3b5f));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rst_tab[i]) begin
      rd(8'(4 * i), rst_tab[i]);
      if (i >= 2) chk(pin_word(i), 32'(rst_tab[i]));
    end
    chk({29'h0, bypass}, 32'h7);
    for (int i = 3; i <= 6; i++) begin
      v = 8'($urandom);
      // slowest prescaler keeps the sampling rate legal for the conversions that follow
      if (i == 4) v[7:6] = 2'b11;
      if (i == 3) pw = v;
      wr(8'(4 * i), v);
      chk({31'h0, seen_grst}, 32'h1);
      rd(8'(4 * i), (i == 6) ? {1'b0, v[6:0]} : v);
      chk(pin_word(i), 32'((i == 6) ? {1'b0, v[6:0]} : v));
    end
    chk({25'h0, power, bypass}, {25'h0, pw[3:0], ~pw[3:1]});
    bus(1'b1, 8'h18, ~v, 4'hE);
    rd(8'h18, {1'b0, v[6:0]});
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    rd(8'h09, 8'h00);
    wr(8'h0C, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      val <= 16'($urandom);
      lat <= 8'(2 + $urandom % 60);
      wr(8'h08, cfg_tab[k]);
      chk({30'h0, seen_req, seen_busy}, 32'h3);
      chk({31'h0, seen_grst}, 32'h0);
      wait_idle();
      rd(8'h00, val[7:0] & msk_tab[k][7:0]);
      rd(8'h04, val[15:8] & msk_tab[k][15:8]);
      rd(8'h08, cfg_tab[k] & 8'h7E);
    end
    lat <= 8'h08;
    wr(8'h08, 8'hFE);
    nr = 0;
    lowseen = 0;
    repeat (80) begin
      @(posedge clk);
      if (req === 1'b1) nr++;
      if (busy !== 1'b1) lowseen++;
    end
    chk({31'h0, nr >= 4}, 32'h1);
    chk(32'(lowseen), 32'h0);
    wr(8'h08, 8'h7C);
    wait_idle();
    chk({31'h0, run}, 32'h0);
    d = {2'b01, 5'($urandom), 1'b1};
    wr(8'h1C, d);
    chk({31'h0, seen_req}, 32'h1);
    wait_idle();
    for (int i = 2; i <= 6; i++) begin
      rd(8'(4 * i), (i == 3) ? 8'hF1 : rst_tab[i]);
      chk(pin_word(i), (i == 3) ? 32'hF1 : 32'(rst_tab[i]));
    end
    rd(8'h1C, d & 8'h3F);
    chk(pin_word(7), 32'(d & 8'h3F));
    wr(8'h0C, 8'hF0);
    wr(8'h08, 8'h80);
    chk({30'h0, seen_req, seen_busy}, 32'h0);
    chk({29'h0, bypass}, 32'h7);
    // defaults from a powered-down converter still launches a conversion
    wr(8'h1C, d);
    chk({30'h0, seen_req, power[0]}, 32'h3);
    wait_idle();
    foreach (div_tab[c]) begin
      wr(8'h10, {2'(c), 6'h00});
      gap(1'b0, g);
      chk(g, div_tab[c]);
      gap(1'b1, g);
      chk(g, 4 * div_tab[c]);
    end
    final_report();
  end
endmodule : testbench
